// file: verilog/vpw_link_pkg.sv
/*
 package for the single-wire vpw link front end: symbol times, filter limits,
 crc constants, state enums and the structs that carry grouped signals.
 assumes a 40 mhz system clock; symbol times are nominal values in microseconds, derived counts in clock cycles.
*/
package vpw_link_pkg;
    // clock rate and nominal symbol times
    localparam int CLK_MHZ = 40;
    localparam int SHORT_US = 64;
    localparam int LONG_US = 128;
    localparam int SOF_US = 200;
    localparam int EOF_US = 280;
    localparam int IFS_US = 20;
    localparam int SHORT_CYC = SHORT_US * CLK_MHZ;
    localparam int IFS_CYC = IFS_US * CLK_MHZ;
    // receive noise filter
    localparam logic [3:0] FILT_TOP = 4'hf;
    localparam logic [3:0] FILT_BOTTOM = 4'h0;
    localparam int SYNC_STAGES = 2;
    localparam int FILT_MAX_LAT = 16;
    localparam int ARB_LAT_CYC = SYNC_STAGES + FILT_MAX_LAT + 1;
    // crc and framing
    localparam logic [7:0] CRC_POLY = 8'h1d;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [7:0] CRC_GOOD = 8'hc4;
    localparam logic [3:0] MAX_BYTES = 4'hc;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_EOD} rx_mode_type;
    typedef enum logic [1:0] {TX_IDLE, TX_SOF, TX_BIT} tx_state_type;

    // receive events, one-cycle pulses
    typedef struct packed {
        logic byte_valid;
        logic crc_err;
        logic eof;
        logic invalid;
    } rx_event_type;

    // transmit request from the protocol side
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } tx_req_type;

    // filter state, updated on the falling clock edge
    typedef struct packed {
        logic [3:0] count;
        logic level;
    } filt_state_type;

    // link state of the top module
    typedef struct packed {
        logic [1:0] sync;
        logic filt_prev;
        logic aloop_prev;
        logic [15:0] dur;
        rx_mode_type rx_mode;
        logic [7:0] rx_sh;
        logic [7:0] rx_crc;
        logic [2:0] rx_bit;
        logic [3:0] rx_bytes;
        logic [7:0] rx_data;
        rx_event_type rx_ev;
        tx_state_type tx_state;
        logic [15:0] tx_cnt;
        logic [7:0] tx_sh;
        logic [7:0] tx_crc;
        logic [2:0] tx_bit;
        logic [3:0] tx_bytes;
        logic tx_last;
        logic tx_crc_phase;
        logic tx_level;
        logic tx_pin;
        logic tx_abort;
        logic tx_done;
    } link_state_type;
endpackage : vpw_link_pkg

// file: verilog/vpw_rx_filter.sv
/*
 receive noise filter: saturating 4-bit up/down counter with an output latch.
 assumes sample_i is already in the clock domain (synchronised or internal).
*/
module vpw_rx_filter (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic sample_i,
    output logic level_o,
    output logic [3:0] count_o
);
    logic sample_reg;
    vpw_link_pkg::filt_state_type state_reg, state_next;

    // input sampled on the rising edge
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= sample_i;
        end
    end

    // count step and latch decision for the falling edge
    always_comb begin
        state_next = state_reg;
        if (sample_reg && state_reg.count != vpw_link_pkg::FILT_TOP) begin
            state_next.count = state_reg.count + 4'h1;
        end else if (!sample_reg && state_reg.count != vpw_link_pkg::FILT_BOTTOM) begin
            state_next.count = state_reg.count - 4'h1;
        end
        if (state_next.count == vpw_link_pkg::FILT_TOP) begin
            state_next.level = 1'b1;
        end else if (state_next.count == vpw_link_pkg::FILT_BOTTOM) begin
            state_next.level = 1'b0;
        end
    end

    // count applied on the falling edge, latch held between end points
    always_ff @(negedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.level;
    assign count_o = state_reg.count;

    sequence high_run_s;
        sample_reg [*8] ##1 sample_reg [*7];
    endsequence

    // fifteen low samples in a row must have pulled the count to zero
    sequence low_run_s;
        !sample_reg [*8] ##1 !sample_reg [*7];
    endsequence

    property latch_sets_p;
        @(negedge clk_i) disable iff (reset_i) $rose(state_reg.level) |-> state_reg.count == 4'hf;
    endproperty

    filt_latch_set_a: assert property (latch_sets_p) else $error("filter output rose below top count");
    filt_latch_clr_a: assert property (@(negedge clk_i) disable iff (reset_i)
        $fell(state_reg.level) |-> state_reg.count == 4'h0) else $error("filter output fell above zero");
    filt_hold_a: assert property (@(negedge clk_i) disable iff (reset_i)
        (state_reg.count != 4'hf && state_reg.count != 4'h0) |-> $stable(state_reg.level))
        else $error("filter output moved at a middle count");
    filt_step_a: assert property (@(negedge clk_i) disable iff (reset_i)
        ($past(state_reg.count) != 4'hf && $past(sample_reg)) |-> state_reg.count == $past(state_reg.count) + 4'h1)
        else $error("filter count did not step up");
    filt_delay_a: assert property (@(posedge clk_i) disable iff (reset_i)
        high_run_s |-> level_o) else $error("filter output late after steady high");
    filt_fall_a: assert property (@(posedge clk_i) disable iff (reset_i)
        low_run_s |-> !level_o) else $error("filter output late after steady low");
endmodule : vpw_rx_filter

// file: verilog/vpw_link_mux.sv
/*
 mux interface of a byte link controller for a vpw single-wire bus: pin
 synchroniser, noise filter, vpw symbol encode and decode, crc-8 framing and
 both loopback modes. assumes an analog transceiver on the pins with high =
 active bus, and a protocol handler on the byte ports in the same clock domain.
*/
module vpw_link_mux #(
    parameter int LONG_CYC = vpw_link_pkg::LONG_US * vpw_link_pkg::CLK_MHZ,
    parameter int SOF_CYC = vpw_link_pkg::SOF_US * vpw_link_pkg::CLK_MHZ,
    parameter int EOF_CYC = vpw_link_pkg::EOF_US * vpw_link_pkg::CLK_MHZ
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic RX_PIN_I,
    output logic TX_PIN_O,
    input wire logic DLOOP_I,
    input wire logic ALOOP_I,
    input wire vpw_link_pkg::tx_req_type TX_REQ_I,
    output logic TX_READY_O,
    output logic TX_DONE_O,
    output logic TX_ABORT_O,
    output logic [7:0] RX_DATA_O,
    output vpw_link_pkg::rx_event_type RX_EVENT_O,
    output logic FILT_RX_O,
    output logic BUS_IDLE_O
);
    // decode limits sit halfway between neighbouring nominal lengths, the minimum at half a short symbol
    localparam logic [15:0] SHORT_T = 16'(vpw_link_pkg::SHORT_CYC);
    localparam logic [15:0] LONG_T = 16'(LONG_CYC);
    localparam logic [15:0] SOF_T = 16'(SOF_CYC);
    localparam logic [15:0] EOF_T = 16'(EOF_CYC);
    localparam logic [15:0] MIN_T = 16'(vpw_link_pkg::SHORT_CYC / 2);
    localparam logic [15:0] LIM_SL = 16'((vpw_link_pkg::SHORT_CYC + LONG_CYC) / 2);
    localparam logic [15:0] LIM_LS = 16'((LONG_CYC + SOF_CYC) / 2);
    localparam logic [15:0] LIM_BRK = 16'((SOF_CYC + EOF_CYC) / 2);
    localparam logic [15:0] IDLE_T = 16'(EOF_CYC + vpw_link_pkg::IFS_CYC);
    localparam logic [15:0] ARB_T = 16'(vpw_link_pkg::ARB_LAT_CYC);

    vpw_link_pkg::link_state_type state_reg, state_next;
    logic filt_level;
    logic filt_in;
    logic bus_idle;
    logic edge_seen;
    logic bit_val;
    logic tx_long;
    logic [7:0] tx_crc_n;
    logic [7:0] rx_sh_n;

    // one serial step of the crc shift register
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
        crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ din) ? vpw_link_pkg::CRC_POLY : 8'h00);
    endfunction : crc_step

    // digital loopback feeds the transmit level straight into the filter
    assign filt_in = DLOOP_I ? state_reg.tx_level : state_reg.sync[1];

    vpw_rx_filter filter_u (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .sample_i(filt_in),
        .level_o(filt_level),
        .count_o()
    );

    assign bus_idle = !filt_level && state_reg.dur >= IDLE_T;
    assign edge_seen = filt_level != state_reg.filt_prev;

    // next state of the receive path, the idle timer and the transmitter
    always_comb begin
        state_next = state_reg;
        TX_READY_O = 1'b0;
        bit_val = 1'b0;
        rx_sh_n = state_reg.rx_sh;
        tx_long = 1'b0;
        tx_crc_n = state_reg.tx_crc;
        state_next.rx_ev = '0;
        state_next.tx_abort = 1'b0;
        state_next.tx_done = 1'b0;
        state_next.sync = {state_reg.sync[0], RX_PIN_I};
        state_next.filt_prev = filt_level;
        state_next.aloop_prev = ALOOP_I;

        // length of the current bus level, saturating at idle
        if (edge_seen) begin
            state_next.dur = 16'h0001;
        end else if (state_reg.dur < IDLE_T) begin
            state_next.dur = state_reg.dur + 16'h0001;
        end

        // receive: classify the level that just ended
        if (edge_seen && state_reg.filt_prev) begin
            if (state_reg.dur >= LIM_BRK) begin
                state_next.rx_ev.invalid = 1'b1;
                state_next.rx_mode = vpw_link_pkg::RX_IDLE;
            end else if (state_reg.dur >= LIM_LS) begin
                if (state_reg.rx_mode == vpw_link_pkg::RX_DATA) begin
                    state_next.rx_ev.invalid = 1'b1;
                    state_next.rx_mode = vpw_link_pkg::RX_IDLE;
                end else begin
                    state_next.rx_mode = vpw_link_pkg::RX_DATA;
                    state_next.rx_crc = vpw_link_pkg::CRC_INIT;
                    state_next.rx_bit = 3'h0;
                    state_next.rx_bytes = 4'h0;
                end
            end else if (state_reg.rx_mode == vpw_link_pkg::RX_DATA) begin
                if (state_reg.dur < MIN_T) begin
                    state_next.rx_ev.invalid = 1'b1;
                    state_next.rx_mode = vpw_link_pkg::RX_IDLE;
                end else begin
                    bit_val = state_reg.dur < LIM_SL;
                end
            end
        end else if (edge_seen) begin
            if (state_reg.rx_mode == vpw_link_pkg::RX_DATA) begin
                if (state_reg.dur < MIN_T) begin
                    state_next.rx_ev.invalid = 1'b1;
                    state_next.rx_mode = vpw_link_pkg::RX_IDLE;
                end else begin
                    bit_val = state_reg.dur >= LIM_SL;
                end
            end else begin
                state_next.rx_mode = vpw_link_pkg::RX_IDLE;
            end
        end

        // receive: shift a valid bit, msb first, through the crc
        if (edge_seen && state_reg.rx_mode == vpw_link_pkg::RX_DATA && !state_next.rx_ev.invalid
            && state_next.rx_mode == vpw_link_pkg::RX_DATA) begin
            rx_sh_n = {state_reg.rx_sh[6:0], bit_val};
            state_next.rx_sh = rx_sh_n;
            state_next.rx_crc = crc_step(state_reg.rx_crc, bit_val);
            state_next.rx_bit = state_reg.rx_bit + 3'h1;
            if (state_reg.rx_bit == vpw_link_pkg::LAST_BIT) begin
                if (state_reg.rx_bytes == vpw_link_pkg::MAX_BYTES) begin
                    state_next.rx_ev.invalid = 1'b1;
                    state_next.rx_mode = vpw_link_pkg::RX_IDLE;
                end else begin
                    state_next.rx_bytes = state_reg.rx_bytes + 4'h1;
                    state_next.rx_data = rx_sh_n;
                    state_next.rx_ev.byte_valid = 1'b1;
                end
            end
        end

        // receive: passive timeouts give end of data and end of frame
        if (!edge_seen && !filt_level) begin
            if (state_reg.rx_mode == vpw_link_pkg::RX_DATA && state_reg.dur == LIM_LS) begin
                state_next.rx_mode = vpw_link_pkg::RX_EOD;
                if (state_reg.rx_bit != 3'h0 || state_reg.rx_bytes < 4'h2) begin
                    state_next.rx_ev.invalid = 1'b1;
                    state_next.rx_mode = vpw_link_pkg::RX_IDLE;
                end else if (state_reg.rx_crc != vpw_link_pkg::CRC_GOOD) begin
                    state_next.rx_ev.crc_err = 1'b1;
                end
            end else if (state_reg.rx_mode == vpw_link_pkg::RX_EOD && state_reg.dur == EOF_T) begin
                state_next.rx_ev.eof = 1'b1;
                state_next.rx_mode = vpw_link_pkg::RX_IDLE;
            end
        end

        // leaving analog loopback restarts the idle wait
        if (state_reg.aloop_prev && !ALOOP_I) begin
            state_next.dur = 16'h0000;
            state_next.rx_mode = vpw_link_pkg::RX_IDLE;
        end

        // transmit sequencer
        unique case (state_reg.tx_state)
            vpw_link_pkg::TX_IDLE: begin
                state_next.tx_level = 1'b0;
                if (bus_idle && TX_REQ_I.valid) begin
                    TX_READY_O = 1'b1;
                    state_next.tx_sh = TX_REQ_I.data;
                    state_next.tx_last = TX_REQ_I.last;
                    state_next.tx_bytes = 4'h1;
                    state_next.tx_crc = vpw_link_pkg::CRC_INIT;
                    state_next.tx_crc_phase = 1'b0;
                    state_next.tx_cnt = 16'h0000;
                    state_next.tx_level = 1'b1;
                    state_next.tx_state = vpw_link_pkg::TX_SOF;
                end
            end
            vpw_link_pkg::TX_SOF: begin
                state_next.tx_cnt = state_reg.tx_cnt + 16'h0001;
                if (state_reg.tx_cnt == SOF_T - 16'h0001) begin
                    state_next.tx_cnt = 16'h0000;
                    state_next.tx_bit = 3'h0;
                    state_next.tx_level = 1'b0;
                    state_next.tx_state = vpw_link_pkg::TX_BIT;
                end
            end
            vpw_link_pkg::TX_BIT: begin
                tx_long = state_reg.tx_sh[7] ^ state_reg.tx_level;
                tx_crc_n = crc_step(state_reg.tx_crc, state_reg.tx_sh[7]);
                state_next.tx_cnt = state_reg.tx_cnt + 16'h0001;
                if (!state_reg.tx_level && filt_level && state_reg.tx_cnt >= ARB_T) begin
                    state_next.tx_abort = 1'b1;
                    state_next.tx_level = 1'b0;
                    state_next.tx_state = vpw_link_pkg::TX_IDLE;
                end else if (state_reg.tx_cnt == (tx_long ? LONG_T : SHORT_T) - 16'h0001) begin
                    state_next.tx_cnt = 16'h0000;
                    state_next.tx_level = !state_reg.tx_level;
                    state_next.tx_sh = {state_reg.tx_sh[6:0], 1'b0};
                    state_next.tx_bit = state_reg.tx_bit + 3'h1;
                    if (!state_reg.tx_crc_phase) begin
                        state_next.tx_crc = tx_crc_n;
                    end
                    if (state_reg.tx_bit == vpw_link_pkg::LAST_BIT) begin
                        if (state_reg.tx_crc_phase) begin
                            state_next.tx_done = 1'b1;
                            state_next.tx_state = vpw_link_pkg::TX_IDLE;
                        end else if (state_reg.tx_last) begin
                            state_next.tx_sh = ~tx_crc_n;
                            state_next.tx_crc_phase = 1'b1;
                        end else if (TX_REQ_I.valid) begin
                            TX_READY_O = 1'b1;
                            state_next.tx_sh = TX_REQ_I.data;
                            state_next.tx_last = TX_REQ_I.last
                                || state_reg.tx_bytes == vpw_link_pkg::MAX_BYTES - 4'h2;
                            state_next.tx_bytes = state_reg.tx_bytes + 4'h1;
                        end else begin
                            state_next.tx_abort = 1'b1;
                            state_next.tx_level = 1'b0;
                            state_next.tx_state = vpw_link_pkg::TX_IDLE;
                        end
                    end
                end
            end
        endcase

        // the pin stays passive while the node is looped back digitally
        state_next.tx_pin = state_next.tx_level && !DLOOP_I;
    end

    // single state register
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign TX_PIN_O = state_reg.tx_pin;
    assign TX_DONE_O = state_reg.tx_done;
    assign TX_ABORT_O = state_reg.tx_abort;
    assign RX_DATA_O = state_reg.rx_data;
    assign RX_EVENT_O = state_reg.rx_ev;
    assign FILT_RX_O = filt_level;
    assign BUS_IDLE_O = bus_idle;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    sequence sof_start_s;
        state_reg.tx_state == vpw_link_pkg::TX_IDLE ##1 state_reg.tx_state == vpw_link_pkg::TX_SOF;
    endsequence

    sequence sof_end_s;
        state_reg.tx_state == vpw_link_pkg::TX_SOF ##1 state_reg.tx_state == vpw_link_pkg::TX_BIT;
    endsequence

    dloop_quiet_a: assert property (DLOOP_I |=> !TX_PIN_O) else $error("pin driven in digital loopback");
    aloop_exit_a: assert property ($fell(ALOOP_I) |=> ##1 !BUS_IDLE_O) else $error("bus idle right after loopback exit");
    sof_length_a: assert property (sof_end_s |-> $past(state_reg.tx_cnt, 1) == SOF_T - 16'h0001)
        else $error("start symbol length wrong");
    sof_crc_init_a: assert property (sof_start_s |-> state_reg.tx_crc == 8'hff && state_reg.tx_level)
        else $error("crc not preset at start symbol");
    crc_check_a: assert property ((state_reg.rx_mode == vpw_link_pkg::RX_DATA && !edge_seen && !filt_level
        && state_reg.dur == LIM_LS && state_reg.rx_bit == 3'h0 && state_reg.rx_bytes >= 4'h2)
        |=> RX_EVENT_O.crc_err == ($past(state_reg.rx_crc) != 8'hc4)) else $error("crc verdict wrong");
    eod_quiet_a: assert property ($rose(state_reg.rx_mode == vpw_link_pkg::RX_EOD) |-> !RX_EVENT_O.eof
        && !RX_EVENT_O.invalid) else $error("flag raised at end of data");
    eof_flag_a: assert property (RX_EVENT_O.eof |-> $past(state_reg.dur) == EOF_T && !$past(FILT_RX_O))
        else $error("end of frame at wrong time");
    byte_limit_a: assert property (state_reg.rx_bytes <= 4'hc && state_reg.tx_bytes <= 4'hb)
        else $error("message longer than twelve bytes");
    arb_wait_a: assert property (TX_ABORT_O && $past(state_reg.tx_state) == vpw_link_pkg::TX_BIT
        |-> $past(state_reg.tx_cnt) >= ARB_T) else $error("arbitration lost too early");
    start_gate_a: assert property (TX_READY_O && state_reg.tx_state == vpw_link_pkg::TX_IDLE |-> BUS_IDLE_O)
        else $error("frame started before bus idle");
endmodule : vpw_link_mux

// file: bench/vpw_xcvr_model.sv
/*
 model of the off-chip analog transceiver and the single wire it drives.
 assumes active-high levels on both pins and a passive pull-down on the wire.
*/
module vpw_xcvr_model (
    input wire logic tx_pin_i,
    input wire logic noise_i,
    output logic rx_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // wired bus: any active driver wins, released wire falls passive
    assign rx_pin_o = tx_pin_i | noise_i;
endmodule : vpw_xcvr_model

// file: bench/tb.sv
/*
 self-checking bench for the vpw mux interface: filter, loopback and framing.
 assumes the transceiver model on the pins and default symbol parameters.
*/
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, reset = 1'b1, dloop = 1'b0, aloop = 1'b0, noise = 1'b0;
    logic rx_pin, tx_pin, tx_ready, tx_done, tx_abort, filt, bus_idle;
    logic [7:0] rx_data;
    vpw_link_pkg::tx_req_type tx_req = 10'h000;
    vpw_link_pkg::rx_event_type ev;
    int miscompares = 0, checks = 0;
    // clock at 40 mhz
    initial begin
        forever #12.5 clk = ~clk;
    end
    vpw_xcvr_model u_vpw_xcvr_model (.tx_pin_i(tx_pin), .noise_i(noise), .rx_pin_o(rx_pin));
    vpw_link_mux u_vpw_link_mux (.CLK_I(clk), .RESET_I(reset), .RX_PIN_I(rx_pin), .TX_PIN_O(tx_pin),
        .DLOOP_I(dloop), .ALOOP_I(aloop), .TX_REQ_I(tx_req), .TX_READY_O(tx_ready), .TX_DONE_O(tx_done),
        .TX_ABORT_O(tx_abort), .RX_DATA_O(rx_data), .RX_EVENT_O(ev), .FILT_RX_O(filt), .BUS_IDLE_O(bus_idle));
    // compare and count
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task stop_test;
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // bounded wait for an idle bus
    task wait_idle;
        int n;
        n = 0;
        while (bus_idle !== 1'b1 && n < 13000) begin
            @(negedge clk);
            n++;
        end
        check("idle_reached", {7'h00, bus_idle}, 8'h01);
        if (n >= 13000) stop_test();
    endtask : wait_idle
    // short pulse vanishes, long pulse passes with the filter delay
    task test_filter;
        int d;
        noise = 1'b1;
        repeat (14) @(negedge clk);
        noise = 1'b0;
        d = 0;
        repeat (30) begin
            @(posedge clk);
            if (filt === 1'b1) d++;
        end
        check("short_pulse", 8'(d), 8'h00);
        @(negedge clk);
        noise = 1'b1;
        d = 0;
        while (filt !== 1'b1 && d < 40) begin
            @(posedge clk);
            d++;
        end
        check("rise_delay", {7'h00, d >= 16 && d <= 19}, 8'h01);
        repeat (30) @(negedge clk);
        noise = 1'b0;
        d = 0;
        while (filt !== 1'b0 && d < 40) begin
            @(posedge clk);
            d++;
        end
        check("fall_delay", {7'h00, d >= 16 && d <= 19}, 8'h01);
    endtask : test_filter
    // leaving analog loopback drops the idle state and holds off a request
    task test_aloop;
        aloop = 1'b1;
        repeat (4) @(negedge clk);
        aloop = 1'b0;
        repeat (3) @(negedge clk);
        check("idle_after_aloop", {7'h00, bus_idle}, 8'h00);
        tx_req = 10'h355;
        #1;
        check("held_off", {7'h00, tx_ready}, 8'h00);
        @(negedge clk);
        tx_req = 10'h000;
    endtask : test_aloop
    // one byte sent and received in digital loopback
    task test_frame;
        int n, hi, nb;
        logic sof_over, crc_e, inv, done, txh, eof;
        logic [7:0] got [2];
        n = 0;
        hi = 0;
        nb = 0;
        {sof_over, crc_e, inv, done, txh, eof} = 6'h00;
        got[0] = 8'h00;
        got[1] = 8'h00;
        dloop = 1'b1;
        wait_idle();
        tx_req = 10'h355;
        #1;
        check("first_take", {7'h00, tx_ready}, 8'h01);
        @(negedge clk);
        tx_req = 10'h000;
        while (!eof && n < 80000) begin
            @(posedge clk);
            #1;
            n++;
            if (filt === 1'b1 && !sof_over) hi++;
            if (filt === 1'b0 && hi > 0) sof_over = 1'b1;
            if (ev.byte_valid === 1'b1 && nb < 2) got[nb] = rx_data;
            if (ev.byte_valid === 1'b1) nb++;
            crc_e |= ev.crc_err;
            inv |= ev.invalid;
            done |= tx_done;
            txh |= tx_pin;
            eof = ev.eof;
        end
        check("sof_length", {7'h00, hi >= 7999 && hi <= 8001}, 8'h01);
        check("byte_count", 8'(nb), 8'h02);
        check("data_byte", got[0], 8'h55);
        check("crc_byte", got[1], 8'h8c);
        check("crc_error", {7'h00, crc_e}, 8'h00);
        check("invalid", {7'h00, inv}, 8'h00);
        check("tx_done", {7'h00, done}, 8'h01);
        check("pin_quiet", {7'h00, txh}, 8'h00);
        check("eof_flag", {7'h00, eof}, 8'h01);
        if (n >= 80000) stop_test();
        dloop = 1'b0;
    endtask : test_frame
    // another node drives the bus in our passive bit: the frame is dropped
    task test_arb;
        int n;
        n = 0;
        wait_idle();
        tx_req = 10'h355;
        #1;
        check("arb_take", {7'h00, tx_ready}, 8'h01);
        @(negedge clk);
        tx_req = 10'h000;
        while (tx_pin === 1'b1 && n < 8100) begin
            @(negedge clk);
            n++;
        end
        check("arb_sof_end", {7'h00, tx_pin}, 8'h00);
        repeat (100) @(negedge clk);
        noise = 1'b1;
        n = 0;
        while (tx_abort !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("arb_abort", {7'h00, tx_abort}, 8'h01);
        check("arb_latency", {7'h00, n >= 16 && n <= 22}, 8'h01);
        check("arb_pin", {7'h00, tx_pin}, 8'h00);
        noise = 1'b0;
    endtask : test_arb
    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        check("reset_pin", {7'h00, tx_pin}, 8'h00);
        reset = 1'b0;
        test_filter();
        wait_idle();
        test_aloop();
        test_frame();
        test_arb();
        stop_test();
    end
endmodule : tb
